// File: hw/dmcp_consts.svh
// Functional notes
// R1: I2C slave address is built from both address-select pin levels.
// R2: SPI chip address bit is compared against the low address-select pin.
// R3: Host pulls the latch low before a transaction, high after it.
// R4: Transfer length follows the address and read/write bits sent first.
// R5: Clock pin is an input, or open-collector output while self-booting.
// R6: SPI works with a free-running or a gated serial clock.
// R7: I2C data pin is open collector: pulled low or released only.
// R8: SPI readback drives the output pin, which floats outside reads.
// R9: SPI serial input arrives on the high address-select pin.
// R10: Boot-select high at reset release starts a self-boot in I2C mode; it is ignored in SPI mode.
// R11: Exactly one of I2C or SPI mode, pins assigned per mode.
`ifndef DMCP_CONSTS_SVH
`define DMCP_CONSTS_SVH

// ****************************************************************
// Addressing
// ****************************************************************
`define DMCP_I2C_ADDR_BASE 5'h0e
`define DMCP_SPI_ADDR_BASE 6'h00
`define DMCP_BOOT_CTRL 8'ha1

// ****************************************************************
// Bit and byte counts
// ****************************************************************
`define DMCP_SPI_LAST_BIT 4'h7
`define DMCP_I2C_LAST_BIT 4'h8
`define DMCP_BOOT_LEN 16'h0100

// ****************************************************************
// Timing
// ****************************************************************
`define DMCP_CLK_NS 5
`define DMCP_BOOT_HALF_NS 5000
`define DMCP_BOOT_HALF_CYC \
   ((`DMCP_BOOT_HALF_NS + `DMCP_CLK_NS - 1) / `DMCP_CLK_NS)

`endif

// File: hw/dmcp_pkg.sv
package dmcp_pkg;

   // ****************************************************************
   // Port sequencer states, Gray along the usual path
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_SUB = 4'h3,
      ST_WR = 4'h2,
      ST_RD = 4'h6,
      ST_SKIP = 4'h7,
      ST_BSTART = 4'h5,
      ST_BTX = 4'h4,
      ST_BRX = 4'hc,
      ST_BSTOP = 4'hd
   } dmcp_state_t;

   // ****************************************************************
   // Whole state of the port
   // ****************************************************************
   typedef struct packed {
      dmcp_state_t st;
      logic spi;
      logic boot;
      logic [1:0] init;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] rdsh;
      logic phase;
      logic rw;
      logic ack;
      logic [15:0] addr;
      logic clk_p;
      logic dat_p;
      logic latch_p;
      logic [9:0] div;
      logic [15:0] nbytes;
      logic rd_ld;
      logic clk_oe;
      logic clk_out;
      logic dat_oe;
      logic dat_out;
      logic [15:0] core_addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dmcp_regs_t;

endpackage

// File: hw/dmcp_sync.sv
`timescale 1ns/1ps
module dmcp_sync #(
   parameter int W = 7
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } dmcp_sync_regs_t;

   dmcp_sync_regs_t q_r;
   dmcp_sync_regs_t q_nxt;

   // Two stages; only the second stage is visible
   always_comb
   begin
      q_nxt.meta = async_in;
      q_nxt.stab = q_r.meta;
   end

   // Register the chain
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign sync_out = q_r.stab;

endmodule

// File: hw/dmcp_port.sv
`timescale 1ns/1ps
`include "dmcp_consts.svh"
module dmcp_port (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Mode straps
   input wire logic mode_spi_sel,
   input wire logic boot_from_eeprom_sel,
   // Address select pins; high one is SPI serial in
   input wire logic chip_addr_sel_lo,
   input wire logic chip_addr_sel_hi,
   input wire logic spi_latch_n,
   // Shared clock pin
   input wire logic port_clk_in,
   output logic port_clk_out,
   output logic port_clk_oe,
   // Shared data pin, SPI readback or I2C data
   input wire logic port_dat_in,
   output logic port_dat_out,
   output logic port_dat_oe,
   // Core memory side
   output logic [15:0] core_addr,
   output logic [7:0] core_wdata,
   output logic core_wr,
   output logic core_rd,
   input wire logic [7:0] core_rdata,
   // Status
   output logic spi_active,
   output logic boot_busy
);

   dmcp_pkg::dmcp_regs_t q_r;
   dmcp_pkg::dmcp_regs_t q_nxt;
   logic [6:0] sync_vec;
   logic clk_s, dat_s, latch_s, lo_s, hi_s, boot_s, mode_s;
   logic rise, fall, din, fr_start, fr_end, tick;
   logic [7:0] byte_now;
   logic [3:0] last_bit;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   dmcp_sync #(.W(7)) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .async_in({port_clk_in, port_dat_in, spi_latch_n, chip_addr_sel_lo,
         chip_addr_sel_hi, boot_from_eeprom_sel, mode_spi_sel}),
      .sync_out(sync_vec)
   );

   assign {clk_s, dat_s, latch_s, lo_s, hi_s, boot_s, mode_s} = sync_vec;

   // Address match, per mode
   function automatic logic addr_hit(input logic spi, input logic [6:0] a,
      input logic lo, input logic hi);
      if (spi)
         addr_hit = (a == {`DMCP_SPI_ADDR_BASE, lo}); // R2
      else
         addr_hit = (a == {`DMCP_I2C_ADDR_BASE, hi, lo}); // R1
   endfunction

   // ****************************************************************
   // Edge and frame detection
   // ****************************************************************
   // Only edges are acted on, so a gated clock is as good as a free one
   assign rise = clk_s & ~q_r.clk_p; // R6
   assign fall = ~clk_s & q_r.clk_p; // R6
   assign din = q_r.spi ? hi_s : dat_s; // R9 R11
   assign byte_now = {q_r.sh[6:0], din};
   assign last_bit = q_r.spi ? `DMCP_SPI_LAST_BIT : `DMCP_I2C_LAST_BIT;
   assign fr_start = q_r.spi ? (~latch_s & q_r.latch_p)
      : (clk_s & q_r.clk_p & q_r.dat_p & ~dat_s);
   assign fr_end = q_r.spi ? latch_s
      : (clk_s & q_r.clk_p & ~q_r.dat_p & dat_s);
   assign tick = (q_r.div == 10'(`DMCP_BOOT_HALF_CYC - 1));

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic [3:0] ncnt;
      logic [15:0] na;
      ncnt = 4'h0;
      na = 16'h0000;
      q_nxt = q_r;
      q_nxt.wr = 1'b0;
      q_nxt.rd = 1'b0;
      q_nxt.rd_ld = q_r.rd;
      q_nxt.clk_p = clk_s;
      q_nxt.dat_p = dat_s;
      q_nxt.latch_p = latch_s;
      q_nxt.clk_out = 1'b0;
      // Read data arrives one cycle after the request
      if (q_r.rd_ld)
         q_nxt.rdsh = core_rdata;
      if (q_r.init != 2'h3)
      begin
         // Straps are caught once, after the synchronisers settle
         q_nxt.init = q_r.init + 2'h1;
         if (q_r.init == 2'h2)
         begin
            q_nxt.spi = mode_s; // R11
            q_nxt.boot = boot_s & ~mode_s; // R10
            if (boot_s & ~mode_s)
               q_nxt.st = dmcp_pkg::ST_BSTART; // R10
         end
      end
      else if (q_r.boot)
      begin
         // Self-boot master, clock driven open collector
         q_nxt.div = tick ? 10'h000 : q_r.div + 10'h001;
         if (tick)
         begin
            case (q_r.st)
               dmcp_pkg::ST_BSTART:
               begin
                  if (!q_r.dat_oe)
                     q_nxt.dat_oe = 1'b1;
                  else
                  begin
                     q_nxt.clk_oe = 1'b1; // R5
                     q_nxt.st = dmcp_pkg::ST_BTX;
                     q_nxt.sh = `DMCP_BOOT_CTRL;
                     q_nxt.cnt = 4'h0;
                     q_nxt.dat_oe = ~q_nxt.sh[7];
                  end
               end
               dmcp_pkg::ST_BTX, dmcp_pkg::ST_BRX:
               begin
                  if (q_r.clk_oe)
                     q_nxt.clk_oe = 1'b0; // R5
                  else
                  begin
                     q_nxt.clk_oe = 1'b1; // R5
                     ncnt = q_r.cnt + 4'h1;
                     q_nxt.cnt = ncnt;
                     if (q_r.st == dmcp_pkg::ST_BTX)
                     begin
                        if (q_r.cnt == 4'h8)
                        begin
                           q_nxt.cnt = 4'h0;
                           q_nxt.dat_oe = dat_s;
                           q_nxt.st = dat_s ? dmcp_pkg::ST_BSTOP
                              : dmcp_pkg::ST_BRX;
                        end
                        else
                           q_nxt.dat_oe = (ncnt == 4'h8) ? 1'b0
                              : ~q_r.sh[3'h7 - ncnt[2:0]];
                     end
                     else if (q_r.cnt != 4'h8)
                     begin
                        q_nxt.sh = {q_r.sh[6:0], dat_s};
                        q_nxt.dat_oe = 1'b0;
                        if (q_r.cnt == 4'h7)
                        begin
                           q_nxt.wr = 1'b1;
                           q_nxt.wdata = {q_r.sh[6:0], dat_s};
                           q_nxt.core_addr = q_r.addr;
                           q_nxt.addr = q_r.addr + 16'h0001;
                           q_nxt.nbytes = q_r.nbytes + 16'h0001;
                           // Acknowledge all but the final byte
                           q_nxt.dat_oe =
                              (q_r.nbytes != `DMCP_BOOT_LEN - 16'h0001);
                        end
                     end
                     else if (q_r.nbytes == `DMCP_BOOT_LEN)
                     begin
                        q_nxt.st = dmcp_pkg::ST_BSTOP;
                        q_nxt.dat_oe = 1'b1;
                     end
                     else
                     begin
                        q_nxt.cnt = 4'h0;
                        q_nxt.dat_oe = 1'b0;
                     end
                  end
               end
               dmcp_pkg::ST_BSTOP:
               begin
                  if (q_r.clk_oe)
                     q_nxt.clk_oe = 1'b0;
                  else
                  begin
                     q_nxt.dat_oe = 1'b0;
                     q_nxt.boot = 1'b0;
                     q_nxt.st = dmcp_pkg::ST_IDLE;
                  end
               end
               default:
                  q_nxt.st = dmcp_pkg::ST_IDLE;
            endcase
         end
      end
      else if (fr_end)
      begin
         q_nxt.st = dmcp_pkg::ST_IDLE;
         q_nxt.dat_oe = 1'b0; // R8
         q_nxt.cnt = 4'h0;
      end
      else if (fr_start)
      begin
         q_nxt.st = dmcp_pkg::ST_ADDR;
         // The clock fall that follows an I2C start is not a data bit
         q_nxt.cnt = q_r.spi ? 4'h0 : `DMCP_I2C_LAST_BIT;
         q_nxt.phase = 1'b0;
         q_nxt.ack = 1'b0;
         q_nxt.dat_oe = 1'b0;
      end
      else if (q_r.st != dmcp_pkg::ST_IDLE)
      begin
         // Sample on the rising clock edge
         if (rise && q_r.cnt < 4'h8)
            q_nxt.sh = byte_now;
         if (rise && q_r.cnt == 4'h7)
         begin
            q_nxt.ack = ~q_r.spi;
            // Length of the transfer is steered by the leading bytes
            case (q_r.st)
               dmcp_pkg::ST_ADDR:
               begin
                  if (addr_hit(q_r.spi, byte_now[7:1], lo_s, hi_s))
                  begin
                     q_nxt.rw = byte_now[0]; // R4
                     if (!q_r.spi && byte_now[0])
                     begin
                        q_nxt.st = dmcp_pkg::ST_RD;
                        q_nxt.rd = 1'b1;
                        q_nxt.core_addr = q_r.addr;
                        q_nxt.addr = q_r.addr + 16'h0001;
                     end
                     else
                        q_nxt.st = dmcp_pkg::ST_SUB; // R4
                  end
                  else
                  begin
                     q_nxt.st = dmcp_pkg::ST_SKIP;
                     q_nxt.ack = 1'b0;
                  end
               end
               dmcp_pkg::ST_SUB:
               begin
                  q_nxt.phase = 1'b1;
                  if (!q_r.phase)
                     q_nxt.addr = {byte_now, q_r.addr[7:0]}; // R9
                  else
                  begin
                     na = {q_r.addr[15:8], byte_now};
                     q_nxt.addr = na;
                     q_nxt.st = q_r.rw ? dmcp_pkg::ST_RD
                        : dmcp_pkg::ST_WR; // R4
                     if (q_r.rw)
                     begin
                        q_nxt.rd = 1'b1;
                        q_nxt.core_addr = na;
                        q_nxt.addr = na + 16'h0001;
                     end
                  end
               end
               dmcp_pkg::ST_WR:
               begin
                  q_nxt.wr = 1'b1;
                  q_nxt.wdata = byte_now;
                  q_nxt.core_addr = q_r.addr;
                  q_nxt.addr = q_r.addr + 16'h0001;
               end
               dmcp_pkg::ST_RD:
               begin
                  q_nxt.ack = 1'b0;
                  if (q_r.spi)
                  begin
                     q_nxt.rd = 1'b1;
                     q_nxt.core_addr = q_r.addr;
                     q_nxt.addr = q_r.addr + 16'h0001;
                  end
               end
               default:
                  q_nxt.ack = 1'b0;
            endcase
         end
         // Master acknowledge bit of an I2C read; the address byte's own
         // acknowledge slot is ours and must not count as one
         if (rise && q_r.cnt == 4'h8 && q_r.st == dmcp_pkg::ST_RD
            && !q_r.ack)
         begin
            if (dat_s)
               q_nxt.st = dmcp_pkg::ST_SKIP;
            else
            begin
               q_nxt.rd = 1'b1;
               q_nxt.core_addr = q_r.addr;
               q_nxt.addr = q_r.addr + 16'h0001;
            end
         end
         // Change the data pin on the falling clock edge
         if (fall)
         begin
            ncnt = (q_r.cnt == last_bit) ? 4'h0 : q_r.cnt + 4'h1;
            q_nxt.cnt = ncnt;
            q_nxt.dat_out = 1'b0; // R7
            if (ncnt == 4'h8)
               q_nxt.dat_oe = q_r.ack; // R7
            else if (q_r.st == dmcp_pkg::ST_RD && q_r.spi)
            begin
               q_nxt.dat_oe = 1'b1; // R8
               q_nxt.dat_out = q_r.rdsh[3'h7 - ncnt[2:0]]; // R8
            end
            else if (q_r.st == dmcp_pkg::ST_RD)
               q_nxt.dat_oe = ~q_r.rdsh[3'h7 - ncnt[2:0]]; // R7
            else
               q_nxt.dat_oe = 1'b0; // R8
         end
      end
   end

   // Register the whole state
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   // ****************************************************************
   // Outputs, all straight from flops
   // ****************************************************************
   assign port_clk_out = q_r.clk_out;
   assign port_clk_oe = q_r.clk_oe;
   assign port_dat_out = q_r.dat_out;
   assign port_dat_oe = q_r.dat_oe;
   assign core_addr = q_r.core_addr;
   assign core_wdata = q_r.wdata;
   assign core_wr = q_r.wr;
   assign core_rd = q_r.rd;
   assign spi_active = q_r.spi;
   assign boot_busy = q_r.boot;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence strap_boot_s;
      q_r.init == 2'h2 && boot_s && !mode_s;
   endsequence
   sequence boot_go_s;
      q_r.st == dmcp_pkg::ST_BSTART && q_r.boot ##[1:1000] q_r.dat_oe;
   endsequence

   i2c_addr_a: assert property (q_r.st == dmcp_pkg::ST_ADDR && rise // R1
      && q_r.cnt == 4'h7 && !q_r.spi && q_r.init == 2'h3
      && byte_now[7:1] == {`DMCP_I2C_ADDR_BASE, hi_s, lo_s}
      |=> q_r.st inside {dmcp_pkg::ST_SUB, dmcp_pkg::ST_RD})
      else $error("i2c address not accepted");
   spi_addr_a: assert property (q_r.st == dmcp_pkg::ST_ADDR && rise // R2
      && q_r.cnt == 4'h7 && q_r.spi && !latch_s
      && byte_now[7:1] != {`DMCP_SPI_ADDR_BASE, lo_s}
      |=> q_r.st == dmcp_pkg::ST_SKIP)
      else $error("spi address mismatch not skipped");
   wr_len_a: assert property (q_r.wr && !q_r.boot // R4
      |-> $past(q_r.st) == dmcp_pkg::ST_WR)
      else $error("write outside data phase");
   clk_pin_a: assert property (q_r.clk_oe // R5
      |-> q_r.boot && !q_r.spi && !q_r.clk_out)
      else $error("clock pin driven outside self-boot");
   spi_idle_a: assert property (q_r.spi && latch_s && q_r.init == 2'h3 // R3
      |=> q_r.st == dmcp_pkg::ST_IDLE && !q_r.dat_oe)
      else $error("spi not idle with latch high");
   sda_od_a: assert property (!q_r.spi |-> !q_r.dat_out) // R7
      else $error("i2c data driven high");
   spi_readback_out_z_a: assert property (q_r.spi && q_r.dat_oe // R8
      |-> q_r.st == dmcp_pkg::ST_RD)
      else $error("readback pin driven outside read");
   hi_data_a: assert property (q_r.st == dmcp_pkg::ST_SUB && rise // R9
      && q_r.cnt == 4'h7 && !q_r.phase && q_r.spi && !latch_s
      |=> q_r.addr[15:8] == $past(byte_now))
      else $error("spi address byte not taken from serial in");
   boot_start_a: assert property (strap_boot_s |=> boot_go_s) // R10
      else $error("self-boot did not start");
   one_mode_a: assert property (q_r.init == 2'h3 |=> $stable(q_r.spi)) // R11
      else $error("mode changed during operation");

endmodule

// File: test/dmcp_host_model.sv
`timescale 1ns/1ps
module dmcp_host_model (
   // Clock
   input wire logic clk_sys,
   // Resolved level of the shared data pin
   input wire logic dat_pin,
   // SPI host lines
   output logic spi_serial_clock,
   output logic spi_latch_n,
   output logic spi_serial_in,
   // I2C lines, 1 = released to the pull-up
   output logic i2c_clk_rel,
   output logic i2c_dat_rel
);
   // ****************************************************************
   // Host side of the control port
   // ****************************************************************
   localparam int H = 40;
   logic free_run;
   logic gate;
   int ph;

   // Idle: clock low, latch high, bus released
   initial
   begin
      {spi_serial_clock, spi_serial_in, free_run, gate} = 4'h0;
      {spi_latch_n, i2c_clk_rel, i2c_dat_rel} = 3'h7;
      ph = 0;
   end

   // 16 cycles a half; a gated clock always finishes its high half
   always @(negedge clk_sys)
   begin
      ph <= (ph == 15) ? 0 : ph + 1;
      if (ph == 15 && (gate || free_run || spi_serial_clock))
         spi_serial_clock <= ~spi_serial_clock;
   end

   // Open on a low clock so that the first edge the device sees is a rise
   task automatic spi_open();
      if (free_run)
         @(negedge spi_serial_clock);
      while (spi_serial_clock)
         @(negedge clk_sys);
      spi_latch_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      gate = 1'b1;
   endtask

   // Data moves on falling edges, readback taken on rising edges
   task automatic spi_bits(input logic [7:0] v, input int n,
      output logic [7:0] rx);
      for (int i = 0; i < n; i++)
      begin
         spi_serial_in = v[7 - i];
         @(posedge spi_serial_clock);
         rx = {rx[6:0], dat_pin};
         @(negedge spi_serial_clock);
      end
   endtask

   // Latch rises only after the last falling edge
   task automatic spi_close();
      repeat (4) @(negedge clk_sys);
      spi_latch_n = 1'b1;
      gate = 1'b0;
   endtask

   task automatic i2c_wait();
      repeat (H) @(negedge clk_sys);
   endtask

   task automatic i2c_start();
      i2c_dat_rel = 1'b0;
      i2c_wait();
      i2c_clk_rel = 1'b0;
      i2c_wait();
   endtask

   task automatic i2c_stop();
      i2c_dat_rel = 1'b0;
      i2c_wait();
      i2c_clk_rel = 1'b1;
      i2c_wait();
      i2c_dat_rel = 1'b1;
      i2c_wait();
   endtask

   // Ninth clock leaves data released so the device can acknowledge
   task automatic i2c_byte(input logic [7:0] v, output logic ack);
      for (int i = 0; i < 9; i++)
      begin
         repeat (4) @(negedge clk_sys);
         i2c_dat_rel = (i < 8) ? v[7 - i] : 1'b1;
         i2c_wait();
         i2c_clk_rel = 1'b1;
         i2c_wait();
         if (i == 8)
            ack = ~dat_pin;
         i2c_clk_rel = 1'b0;
      end
   endtask
endmodule

// File: test/dual_mode_control_port_pins_tb.sv
`timescale 1ns/1ps
module dual_mode_control_port_pins_tb;
   // ****************************************************************
   // Bench for the dual-mode control port
   // ****************************************************************
   typedef struct packed {
      logic lo;
      logic [7:0] b0;
      logic [15:0] a;
      logic [7:0] d;
      logic ok;
   } dmcp_tb_row_t;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic mode, boot, lo, hi_s, flt, oe_seen, ck_seen, i2c_hi;
   logic clk_oe, clk_out, dat_oe, dat_out, core_wr, core_rd;
   logic spi_active, boot_busy, sclk, latch_n, sdi, scl_r, sda_r;
   logic a0, a1, a2, a3;
   logic rd_cap = 1'b0;
   logic rd_got = 1'b0;
   logic [15:0] core_addr, wr_a, rd_a;
   logic [7:0] core_wdata, wr_d, rx, bsh;
   logic [7:0] core_rdata = 8'h00;
   int n_fail = 0;
   int tests_run = 0;
   int n_wr = 0;
   int bn = 0;
   // Undriven SPI readback toggles so a stale value cannot pass
   wire logic dat_pin = mode ? (dat_oe ? dat_out : flt) : (~dat_oe & sda_r);
   wire logic clk_pin = mode ? sclk : (~clk_oe & scl_r);
   // Rows: lo pin, command byte, address, data, accepted
   dmcp_tb_row_t rows [7] = '{
      '{1'b0, 8'h00, 16'h1234, 8'ha5, 1'b1},
      '{1'b1, 8'h02, 16'hffff, 8'h3c, 1'b1},
      '{1'b1, 8'h00, 16'h0042, 8'h11, 1'b0},
      '{1'b0, 8'h01, 16'h00ff, 8'h00, 1'b1},
      '{1'b1, 8'h03, 16'h8001, 8'h00, 1'b1},
      '{1'b0, 8'h03, 16'h0007, 8'h00, 1'b0},
      '{1'b0, 8'h40, 16'h0005, 8'h77, 1'b0}};

   always #2.5 clk_sys = ~clk_sys;

   dmcp_port dut_u (.clk_sys(clk_sys), .srst(srst), .mode_spi_sel(mode),
      .boot_from_eeprom_sel(boot), .chip_addr_sel_lo(lo),
      .chip_addr_sel_hi(mode ? sdi : hi_s), .spi_latch_n(latch_n),
      .port_clk_in(clk_pin), .port_clk_out(clk_out), .port_clk_oe(clk_oe),
      .port_dat_in(dat_pin), .port_dat_out(dat_out), .port_dat_oe(dat_oe),
      .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr),
      .core_rd(core_rd), .core_rdata(core_rdata),
      .spi_active(spi_active), .boot_busy(boot_busy));

   dmcp_host_model host_u (.clk_sys(clk_sys), .dat_pin(dat_pin),
      .spi_serial_clock(sclk), .spi_latch_n(latch_n),
      .spi_serial_in(sdi), .i2c_clk_rel(scl_r), .i2c_dat_rel(sda_r));

   // Core memory answers with a byte derived from its address
   always @(negedge clk_sys)
   begin
      flt <= ~flt;
      if (!srst)
         core_rdata <= core_addr[7:0] ^ 8'h5a;
   end

   // Record core accesses and pin drive, away from the launching edge
   always @(negedge clk_sys)
   begin
      if (core_wr)
      begin
         n_wr++;
         wr_a = core_addr;
         wr_d = core_wdata;
      end
      // Keep the first read of a frame; reads run one byte ahead
      if (core_rd && !rd_got)
      begin
         rd_a = core_addr;
         rd_got = 1'b1;
      end
      if (dat_oe)
         oe_seen = 1'b1;
      if (clk_oe)
         ck_seen = 1'b1;
      if (dat_out && !mode)
         i2c_hi = 1'b1;
   end

   // First byte the device sends, as boot master or on an I2C read
   always @(posedge clk_pin)
      if ((boot_busy || rd_cap) && bn < 8)
      begin
         bsh = {bsh[6:0], dat_pin};
         bn++;
      end

   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      tests_run++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, s, e);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic rst(input logic m, input logic b);
      mode = m;
      boot = b;
      srst = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk({core_wr, core_rd, dat_oe, clk_oe, spi_active, boot_busy}, 0);
      chk({dat_out, clk_out}, 0);
      srst = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk(spi_active, m);
   endtask

   // Length follows the header: three bytes, nb data bytes, pb stray bits
   task automatic spi_frame(input logic [7:0] b0, input logic [15:0] a,
      input logic [7:0] d, input int nb, input int pb);
      logic [7:0] r;
      host_u.spi_open();
      host_u.spi_bits(b0, 8, r);
      host_u.spi_bits(a[15:8], 8, r);
      host_u.spi_bits(a[7:0], 8, r);
      for (int i = 0; i < nb; i++)
         host_u.spi_bits(d + 8'(i), 8, rx);
      if (pb > 0)
         host_u.spi_bits(8'hf0, pb, r);
      host_u.spi_close();
      repeat (8) @(negedge clk_sys);
   endtask

   // Run is near 40k cycles; 90k means a hang
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      n_fail++;
      give_verdict();
   end

   initial
   begin
      dmcp_tb_row_t r;
      int nw;
      {mode, boot, lo, hi_s, flt, oe_seen, ck_seen, i2c_hi} = 8'h80;
      rst(1'b1, 1'b0);
      // Odd rows run the serial clock freely, even rows gate it
      for (int k = 0; k < 7; k++)
      begin
         r = rows[k];
         lo = r.lo;
         host_u.free_run = k[0];
         nw = n_wr;
         oe_seen = 1'b0;
         rd_got = 1'b0;
         spi_frame(r.b0, r.a, r.d, 1, 0);
         chk(dat_oe, 0);
         chk(oe_seen, r.ok & r.b0[0]);
         if (r.b0[0] && r.ok)
            chk({rd_a, rx}, {r.a, r.a[7:0] ^ 8'h5a});
         if (!r.b0[0])
            chk(n_wr - nw, r.ok);
         if (!r.b0[0] && r.ok)
            chk({wr_a, wr_d}, {r.a, r.d});
      end
      // Burst of two bytes, then a partial byte cut off by the latch
      host_u.free_run = 1'b0;
      lo = 1'b0;
      nw = n_wr;
      spi_frame(8'h00, 16'h00fe, 8'h10, 2, 4);
      chk(n_wr - nw, 2);
      chk({wr_a, wr_d}, {16'h00ff, 8'h11});
      // I2C write to our address, then a frame to another address
      hi_s = 1'b1;
      rst(1'b0, 1'b0);
      host_u.i2c_start();
      host_u.i2c_byte(8'h74, a0);
      host_u.i2c_byte(8'h00, a1);
      host_u.i2c_byte(8'h10, a2);
      host_u.i2c_byte(8'h99, a3);
      host_u.i2c_stop();
      chk({a0, a1, a2, a3}, 4'hf);
      chk({wr_a, wr_d}, {16'h0010, 8'h99});
      nw = n_wr;
      host_u.i2c_start();
      host_u.i2c_byte(8'h70, a0);
      host_u.i2c_stop();
      chk({a0, 8'(n_wr - nw)}, 0);
      // Current-address read of one byte, host answers with no-ack
      bn = 0;
      host_u.i2c_start();
      host_u.i2c_byte(8'h75, a0);
      rd_cap = 1'b1;
      host_u.i2c_byte(8'hff, a1);
      rd_cap = 1'b0;
      host_u.i2c_stop();
      chk({a0, a1, bsh}, {2'h2, 8'h11 ^ 8'h5a});
      chk({i2c_hi, ck_seen}, 0);
      // Self-boot with no EEPROM answering the control byte
      bn = 0;
      rst(1'b0, 1'b1);
      chk(boot_busy, 1);
      for (int w = 0; w < 40000 && boot_busy; w++)
         @(negedge clk_sys);
      chk({boot_busy, bsh, 8'(bn)}, {1'b0, 8'ha1, 8'h08});
      chk(ck_seen, 1);
      give_verdict();
   end
endmodule
